//--- logic/fsp_ctrl.sv
// fast serial port: control/status, rate divisor, transmit gap and data registers
// with byte transmitter, receiver, 8-byte receive store and flow control
// assumes one 200 MHz clock, synchronous reset, and a block engine outside
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - bit 15 switches transmitter, receiver, receive store and request-to-send on/off
// - bit 14 selects request-to-send active level
// - bit 13 selects clear-to-send active level
// - bit 12 sets on stop char, clears on go char
// - bit 11 enables character flow control
// - bit 10 enables handshake-line flow control
// - bit 9 gates receive interrupts
// - bit 8 gates done interrupts
// - bit 7 sets on block send end, write-one clears
// - bit 6 sets on block receive end, write-one clears
// - bit 5 picks one or two stop bits
// - bit 4 shows transmit holding free
// - bit 3 picks receive interrupt source
// - bit 2 sets on receive overflow, write-one clears
// - bit 1 shows receive store full
// - bit 0 shows receive store not empty
// - line rate is 48 MHz over divisor plus one
// - gap register used only in block send
// - idle between bytes is gap minus seven bits
// - data write sends byte, read pops oldest
module fsp_ctrl
  import fsp_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // serial pins
  output logic txd_o,
  input wire logic rxd_i,
  output logic rts_o,
  input wire logic cts_i,
  // block transfer engine
  input wire logic block_tx_i,
  input wire logic block_tx_done_i,
  input wire logic block_rx_done_i,
  // interrupt lines
  output logic rx_irq_line_o,
  output logic done_irq_o
);

  // registers
  logic [15:0] ctrl;
  logic xoff_seen;
  logic tx_done_flag;
  logic rx_done_flag;
  logic rx_ovf_flag;
  logic [12:0] div;
  logic [7:0] gap;
  logic [7:0] tx_hold;
  logic tx_hold_full;
  logic [7:0] rx_mem [FSP_RX_DEPTH];
  logic [2:0] rx_rd_idx;
  logic [2:0] rx_wr_idx;
  logic [3:0] rx_cnt;

  // decoded control bits
  wire port_on = ctrl[FSP_B_PORT_ON];
  wire rts_pol = ctrl[FSP_B_RTS_POL];
  wire cts_pol = ctrl[FSP_B_CTS_POL];
  wire soft_flow_on = ctrl[FSP_B_SOFT_FLOW_ON];
  wire hw_flow_on = ctrl[FSP_B_HW_FLOW_ON];
  wire rx_irq_en = ctrl[FSP_B_RX_IRQ_EN];
  wire done_irq_en = ctrl[FSP_B_DONE_IRQ_EN];
  wire one_stop = ctrl[FSP_B_ONE_STOP];
  wire pkt_sel = ctrl[FSP_B_PKT_SEL];

  // address decode
  wire sel_ctrl = (reg_addr_i == FSP_ADDR_CTRL);
  wire sel_div = (reg_addr_i == FSP_ADDR_DIV);
  wire sel_gap = (reg_addr_i == FSP_ADDR_GAP);
  wire sel_data = (reg_addr_i == FSP_ADDR_DATA);
  wire wr_ctrl = reg_wr_i & sel_ctrl;
  wire wr_data = reg_wr_i & sel_data;
  wire rd_data = reg_rd_i & sel_data;

  // store status
  wire rx_ready = (rx_cnt != 4'h0);
  wire rx_full = (rx_cnt == FSP_RX_FULL_CNT);
  wire tx_ready = ~tx_hold_full;

  // pin synchronisers: cts on bit 1, rxd on bit 0, three stages each
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_flt;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          pin_s1[gi] <= 1'b1;
          pin_s2[gi] <= 1'b1;
          pin_s3[gi] <= 1'b1;
          pin_flt[gi] <= 1'b1;
        end else begin
          pin_s1[gi] <= (gi == 0) ? rxd_i : cts_i;
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_flt[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate
  wire rx_line = pin_flt[0];
  wire cts_true = pin_flt[1] ^ cts_pol;

  // 48 MHz reference ticks made from the 200 MHz clock by a phase accumulator
  logic [8:0] acc;
  wire [8:0] acc_sum = acc + FSP_ACC_STEP;
  wire ref_tick = (acc_sum >= FSP_ACC_WRAP);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      acc <= 9'h000;
    end else begin
      acc <= ref_tick ? acc_sum - FSP_ACC_WRAP : acc_sum;
    end
  end

  // transmitter: one bit lasts div+1 reference ticks
  fsp_tx_state_e tx_state;
  logic [12:0] tx_tcnt;
  logic [7:0] tx_shift;
  logic [2:0] tx_bit;
  logic [7:0] tx_stops;
  wire tx_bit_end = ref_tick & (tx_tcnt == div);
  wire tx_flow_ok = ~(soft_flow_on & xoff_seen) & ~(hw_flow_on & ~cts_true);
  wire tx_go = port_on & tx_hold_full & tx_flow_ok;
  // idle length: gap-7 bits in block send, else the stop-bit choice
  wire [7:0] gap_bits = (gap > 8'h08) ? gap - FSP_GAP_BIAS : 8'h01;
  wire [7:0] next_stops = block_tx_i ? gap_bits : (one_stop ? 8'h01 : 8'h02);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !port_on) begin
      tx_state <= FSP_TX_IDLE;
      tx_tcnt <= 13'h0000;
      tx_shift <= 8'h00;
      tx_bit <= 3'h0;
      tx_stops <= 8'h00;
      txd_o <= 1'b1;
    end else begin
      if (ref_tick) begin
        tx_tcnt <= tx_bit_end ? 13'h0000 : tx_tcnt + 13'h0001;
      end
      case (tx_state)
        FSP_TX_IDLE: begin
          tx_tcnt <= 13'h0000;
          if (tx_go) begin
            tx_state <= FSP_TX_START;
            tx_shift <= tx_hold;
            tx_stops <= next_stops;
            txd_o <= 1'b0;
          end
        end
        FSP_TX_START: begin
          if (tx_bit_end) begin
            tx_state <= FSP_TX_DATA;
            tx_bit <= 3'h0;
            txd_o <= tx_shift[0];
          end
        end
        FSP_TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_bit == FSP_LAST_DATA_BIT) begin
              tx_state <= FSP_TX_STOP;
              txd_o <= 1'b1;
            end else begin
              tx_bit <= tx_bit + 3'h1;
              tx_shift <= {1'b0, tx_shift[7:1]};
              txd_o <= tx_shift[1];
            end
          end
        end
        FSP_TX_STOP: begin
          if (tx_bit_end) begin
            if (tx_stops <= 8'h01) begin
              tx_state <= FSP_TX_IDLE;
            end else begin
              tx_stops <= tx_stops - 8'h01;
            end
          end
        end
        default: tx_state <= FSP_TX_IDLE;
      endcase
    end
  end
  wire tx_take = (tx_state == FSP_TX_IDLE) & tx_go;

  // receiver: centre of start bit after half a bit, then one bit apart
  fsp_rx_state_e rx_state;
  logic [12:0] rx_tcnt;
  logic [12:0] rx_target;
  logic [7:0] rx_shift;
  logic [2:0] rx_bit;
  logic rx_push;
  wire rx_sample = ref_tick & (rx_tcnt == rx_target);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !port_on) begin
      rx_state <= FSP_RX_IDLE;
      rx_tcnt <= 13'h0000;
      rx_target <= 13'h0000;
      rx_shift <= 8'h00;
      rx_bit <= 3'h0;
      rx_push <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (ref_tick) begin
        rx_tcnt <= rx_sample ? 13'h0000 : rx_tcnt + 13'h0001;
      end
      case (rx_state)
        FSP_RX_IDLE: begin
          rx_tcnt <= 13'h0000;
          rx_target <= {1'b0, div[12:1]};
          if (!rx_line) begin
            rx_state <= FSP_RX_START;
          end
        end
        FSP_RX_START: begin
          if (rx_sample) begin
            rx_target <= div;
            rx_bit <= 3'h0;
            rx_state <= rx_line ? FSP_RX_IDLE : FSP_RX_DATA;
          end
        end
        FSP_RX_DATA: begin
          if (rx_sample) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == FSP_LAST_DATA_BIT) begin
              rx_state <= FSP_RX_STOP;
            end
          end
        end
        FSP_RX_STOP: begin
          // any number of stop bits is accepted: only the first is checked
          if (rx_sample) begin
            rx_push <= rx_line;
            rx_state <= rx_line ? FSP_RX_IDLE : FSP_RX_WAIT_HIGH;
          end
        end
        FSP_RX_WAIT_HIGH: begin
          if (rx_line) begin
            rx_state <= FSP_RX_IDLE;
          end
        end
        default: rx_state <= FSP_RX_IDLE;
      endcase
    end
  end

  // flow characters are consumed when character flow control is on
  wire got_xoff = rx_push & soft_flow_on & (rx_shift == FSP_CHAR_XOFF);
  wire got_xon = rx_push & soft_flow_on & (rx_shift == FSP_CHAR_XON);
  wire rx_store = rx_push & ~got_xoff & ~got_xon;
  wire rx_pop = rd_data & rx_ready;
  wire rx_wr_ok = rx_store & (~rx_full | rx_pop);
  wire rx_ovf_set = rx_store & rx_full & ~rx_pop;

  // receive store: 8 bytes in flops with read and write indices
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !port_on) begin
      rx_rd_idx <= 3'h0;
      rx_wr_idx <= 3'h0;
      rx_cnt <= 4'h0;
    end else begin
      if (rx_wr_ok) begin
        rx_mem[rx_wr_idx] <= rx_shift;
        rx_wr_idx <= rx_wr_idx + 3'h1;
      end
      if (rx_pop) begin
        rx_rd_idx <= rx_rd_idx + 3'h1;
      end
      rx_cnt <= rx_cnt + {3'h0, rx_wr_ok} - {3'h0, rx_pop};
    end
  end

  // register writes; hardware sets win over write-one clears
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl <= FSP_CTRL_RST;
      div <= FSP_DIV_RST;
      gap <= FSP_GAP_RST;
      tx_hold <= 8'h00;
      tx_hold_full <= 1'b0;
      xoff_seen <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      rx_ovf_flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata_i & FSP_CTRL_WMASK;
      end
      if (reg_wr_i && sel_div) begin
        div <= reg_wdata_i[12:0];
      end
      if (reg_wr_i && sel_gap) begin
        gap <= reg_wdata_i[7:0];
      end
      if (wr_data) begin
        tx_hold <= reg_wdata_i[7:0];
      end
      tx_hold_full <= (tx_hold_full & ~tx_take) | wr_data;
      xoff_seen <= got_xoff | (xoff_seen & ~got_xon);
      tx_done_flag <= block_tx_done_i | (tx_done_flag & ~(wr_ctrl & reg_wdata_i[FSP_B_TX_DONE]));
      rx_done_flag <= block_rx_done_i | (rx_done_flag & ~(wr_ctrl & reg_wdata_i[FSP_B_RX_DONE]));
      rx_ovf_flag <= rx_ovf_set | (rx_ovf_flag & ~(wr_ctrl & reg_wdata_i[FSP_B_RX_OVF]));
    end
  end

  // control/status view: stored bits plus live flags
  logic [15:0] ctrl_view;
  always_comb begin
    ctrl_view = ctrl;
    ctrl_view[FSP_B_XOFF] = xoff_seen;
    ctrl_view[FSP_B_TX_DONE] = tx_done_flag;
    ctrl_view[FSP_B_RX_DONE] = rx_done_flag;
    ctrl_view[FSP_B_TX_READY] = tx_ready;
    ctrl_view[FSP_B_RX_OVF] = rx_ovf_flag;
    ctrl_view[FSP_B_RX_FULL] = rx_full;
    ctrl_view[FSP_B_RX_READY] = rx_ready;
  end

  // read mux; unmapped addresses read zero
  wire [15:0] rd_mux = sel_ctrl ? ctrl_view :
                       sel_div ? {3'h0, div} :
                       sel_gap ? {8'h00, gap} :
                       sel_data ? {8'h00, rx_mem[rx_rd_idx]} : 16'h0000;

  // read data, request-to-send and interrupt outputs, all registered
  wire rts_true = port_on & hw_flow_on & ~rx_full;
  wire rx_src = pkt_sel ? rx_full : rx_ready;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 16'h0000;
      rts_o <= 1'b0;
      rx_irq_line_o <= 1'b0;
      done_irq_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
      rts_o <= rts_true ^ rts_pol;
      rx_irq_line_o <= rx_irq_en & rx_src;
      done_irq_o <= done_irq_en & (tx_done_flag | rx_done_flag);
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // a data write fills the holding byte and drops ready on the next cycle
  sequence s_byte_loaded;
    wr_data ##1 (tx_hold_full && !ctrl_view[FSP_B_TX_READY] && tx_hold == $past(reg_wdata_i[7:0]));
  endsequence
  sequence s_start_bit;
    (tx_state == FSP_TX_START) && !txd_o;
  endsequence

  AST_PORT_OFF_IDLE: assert property (!port_on |=> txd_o && tx_state == FSP_TX_IDLE)
    else $error("port off but transmitter active");
  AST_RTS_LEVEL: assert property (1'b1 |=> rts_o == ($past(rts_true) ^ $past(rts_pol)))
    else $error("request-to-send level wrong");
  AST_FLOW_HOLD: assert property ((tx_state == FSP_TX_IDLE) && soft_flow_on && xoff_seen && !wr_ctrl
    |=> tx_state == FSP_TX_IDLE)
    else $error("sent while stopped by flow character");
  AST_CTS_HOLD: assert property ((tx_state == FSP_TX_IDLE) && hw_flow_on && !cts_true && !wr_ctrl
    |=> tx_state == FSP_TX_IDLE)
    else $error("sent while clear-to-send false");
  AST_DONE_SET_WINS: assert property (block_tx_done_i |=> ctrl_view[FSP_B_TX_DONE])
    else $error("transmit done event lost");
  AST_DONE_CLEAR: assert property (wr_ctrl && reg_wdata_i[FSP_B_RX_DONE] && !block_rx_done_i
    |=> !rx_done_flag)
    else $error("receive done flag not cleared");
  AST_TX_READY_DROP: assert property (wr_data |-> s_byte_loaded)
    else $error("transmit ready not dropped after load");
  AST_TX_START: assert property (tx_take |=> s_start_bit ##1 !txd_o)
    else $error("start bit not driven");
  AST_OVF_SET: assert property (rx_ovf_set |=> rx_ovf_flag && rx_cnt == FSP_RX_FULL_CNT)
    else $error("overflow not flagged");
  AST_FULL_FLAG: assert property (rx_cnt == FSP_RX_FULL_CNT |-> ctrl_view[FSP_B_RX_FULL] && ctrl_view[0])
    else $error("full flag wrong");
  AST_RX_IRQ: assert property (rx_irq_en && rx_src |=> rx_irq_line_o)
    else $error("receive interrupt missing");
  AST_DIV_WRITE: assert property (reg_wr_i && sel_div |=> div == $past(reg_wdata_i[12:0]))
    else $error("divisor not stored");

endmodule

`default_nettype wire

//--- logic/fsp_pkg.sv
// fast serial port: register map, field positions, reset values, timing
// assumes a single 200 MHz system clock and a 16-bit register port
package fsp_pkg;

  // register byte addresses
  localparam logic [15:0] FSP_ADDR_CTRL = 16'hC070;
  localparam logic [15:0] FSP_ADDR_DIV = 16'hC072;
  localparam logic [15:0] FSP_ADDR_GAP = 16'hC074;
  localparam logic [15:0] FSP_ADDR_DATA = 16'hC076;

  // control and status field positions
  localparam int FSP_B_PORT_ON = 15;
  localparam int FSP_B_RTS_POL = 14;
  localparam int FSP_B_CTS_POL = 13;
  localparam int FSP_B_XOFF = 12;
  localparam int FSP_B_SOFT_FLOW_ON = 11;
  localparam int FSP_B_HW_FLOW_ON = 10;
  localparam int FSP_B_RX_IRQ_EN = 9;
  localparam int FSP_B_DONE_IRQ_EN = 8;
  localparam int FSP_B_TX_DONE = 7;
  localparam int FSP_B_RX_DONE = 6;
  localparam int FSP_B_ONE_STOP = 5;
  localparam int FSP_B_TX_READY = 4;
  localparam int FSP_B_PKT_SEL = 3;
  localparam int FSP_B_RX_OVF = 2;
  localparam int FSP_B_RX_FULL = 1;
  localparam int FSP_B_RX_READY = 0;

  // values after reset
  localparam logic [15:0] FSP_CTRL_RST = 16'h0000;
  localparam logic [12:0] FSP_DIV_RST = 13'h0017;
  localparam logic [7:0] FSP_GAP_RST = 8'h09;

  // writable control bits (flags and read-only bits masked out)
  localparam logic [15:0] FSP_CTRL_WMASK = 16'hEF28;

  // gap value minus this many gives idle bit times
  localparam logic [7:0] FSP_GAP_BIAS = 8'h07;

  // software flow characters
  localparam logic [7:0] FSP_CHAR_XON = 8'h11;
  localparam logic [7:0] FSP_CHAR_XOFF = 8'h13;

  // receive store
  localparam int FSP_RX_DEPTH = 8;
  localparam logic [3:0] FSP_RX_FULL_CNT = 4'h8;

  // timing: reference rate and system clock period
  localparam int FSP_REF_MHZ = 48;
  localparam int FSP_CLK_PERIOD_NS = 5;
  localparam int FSP_CLK_MHZ = 1000 / FSP_CLK_PERIOD_NS;
  localparam logic [8:0] FSP_ACC_STEP = 9'(FSP_REF_MHZ);
  localparam logic [8:0] FSP_ACC_WRAP = 9'(FSP_CLK_MHZ);

  // frame shape
  localparam logic [2:0] FSP_LAST_DATA_BIT = 3'h7;

  typedef enum {FSP_TX_IDLE, FSP_TX_START, FSP_TX_DATA, FSP_TX_STOP} fsp_tx_state_e;
  typedef enum {FSP_RX_IDLE, FSP_RX_START, FSP_RX_DATA, FSP_RX_STOP, FSP_RX_WAIT_HIGH} fsp_rx_state_e;

endpackage

//--- testbench/fsp_far_uart.sv
// far-side serial device: sends frames on rxd, decodes frames on txd
// assumes 100 system clocks per bit, i.e. the reset divisor
`timescale 1ns/1ps
`default_nettype none
module fsp_far_uart #(
  parameter int BIT = 100
) (
  // clock
  input wire logic clock_i,
  // serial lines
  input wire logic txd_i,
  output logic rxd_o
);
  int cyc = 0;
  int last_start = 0;
  int start_gap = 0;
  int got_cnt = 0;
  logic [7:0] got_byte = 8'h00;
  logic [7:0] sh;

  // free-running cycle count for frame spacing
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
  end

  initial begin
    rxd_o = 1'b1;
  end

  // start, data lsb first, then a caller-chosen stop count
  task automatic send_byte(input logic [7:0] b, input int nstop);
    rxd_o <= 1'b0;
    repeat (BIT) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      rxd_o <= b[i];
      repeat (BIT) @(posedge clock_i);
    end
    rxd_o <= 1'b1;
    repeat (BIT * nstop) @(posedge clock_i);
  endtask

  // decode frames by mid-bit sampling, note start spacing
  initial begin
    forever begin
      @(negedge txd_i);
      start_gap = cyc - last_start;
      last_start = cyc;
      repeat (BIT / 2) @(posedge clock_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clock_i);
        sh[i] = txd_i;
      end
      repeat (BIT) @(posedge clock_i);
      if (txd_i === 1'b1) begin
        got_byte = sh;
        got_cnt++;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/fsp_ctrl_tb_top.sv
// self-checking bench for the fast serial port register block
// assumes fsp_far_uart on the serial lines, divisor kept at reset value
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_tb_top
  import fsp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cts = 1'b0;
  logic blk = 1'b0;
  logic blk_tx_done = 1'b0;
  logic blk_rx_done = 1'b0;
  logic [15:0] rdata;
  logic txd;
  logic rxd;
  logic rts;
  logic rx_irq;
  logic done_irq;
  logic [15:0] v;
  int n;
  int err_total = 0;
  int samples_checked = 0;

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  fsp_ctrl dut (.clock_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .txd_o(txd), .rxd_i(rxd),
    .rts_o(rts), .cts_i(cts), .block_tx_i(blk), .block_tx_done_i(blk_tx_done),
    .block_rx_done_i(blk_rx_done), .rx_irq_line_o(rx_irq), .done_irq_o(done_irq));

  fsp_far_uart u_far (.clock_i(clk), .txd_i(txd), .rxd_o(rxd));

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // register port cycles
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // value compare and time compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input int got, input int exp);
    samples_checked++;
    if (got < exp - 6 || got > exp + 6) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask

  // poll ready, then load one byte
  task automatic send_tx(input logic [7:0] b);
    v = 16'h0000;
    for (int i = 0; i < 3000 && v[FSP_B_TX_READY] !== 1'b1; i++) rd_reg(FSP_ADDR_CTRL, v);
    wr_reg(FSP_ADDR_DATA, {8'h00, b});
  endtask

  task automatic wait_rx(input int cnt);
    for (int i = 0; i < 5000 && u_far.got_cnt < cnt; i++) @(posedge clk);
  endtask

  task automatic t_regs;
    rd_chk(FSP_ADDR_CTRL, 16'h0010);
    rd_chk(FSP_ADDR_DIV, 16'h0017);
    rd_chk(FSP_ADDR_GAP, 16'h0009);
    rd_chk(16'hC07A, 16'h0000);
    wr_reg(FSP_ADDR_DIV, 16'h1387);
    rd_chk(FSP_ADDR_DIV, 16'h1387);
    wr_reg(FSP_ADDR_DIV, 16'h0017);
    wr_reg(FSP_ADDR_CTRL, 16'hFFFF);
    rd_chk(FSP_ADDR_CTRL, 16'hEF38);
    chk({15'h0000, rts}, 16'h0000);
    wr_reg(FSP_ADDR_CTRL, 16'h8400);
    repeat (2) @(posedge clk);
    chk({15'h0000, rts}, 16'h0001);
  endtask

  // back-to-back frames: one stop, two stops, block gap of 0x0A
  task automatic t_frames;
    for (int k = 0; k < 3; k++) begin
      blk <= (k == 2);
      wr_reg(FSP_ADDR_GAP, 16'h000A);
      wr_reg(FSP_ADDR_CTRL, (k == 0) ? 16'h8020 : 16'h8000);
      n = u_far.got_cnt;
      send_tx(8'hA5);
      send_tx(8'h5A);
      wait_rx(n + 2);
      chk({8'h00, u_far.got_byte}, 16'h005A);
      chk_span(u_far.start_gap, 100 * (10 + k));
    end
    blk <= 1'b0;
  endtask

  task automatic t_rx;
    wr_reg(FSP_ADDR_CTRL, 16'h8200);
    u_far.send_byte(8'h3C, 2);
    repeat (20) @(posedge clk);
    chk({15'h0000, rx_irq}, 16'h0001);
    rd_chk(FSP_ADDR_CTRL, 16'h8211);
    rd_chk(FSP_ADDR_DATA, 16'h003C);
    repeat (2) @(posedge clk);
    chk({15'h0000, rx_irq}, 16'h0000);
    wr_reg(FSP_ADDR_CTRL, 16'h8608);
    for (int i = 0; i < 9; i++) begin
      if (i == 7) chk({14'h0000, rx_irq, rts}, 16'h0001);
      if (i == 8) begin
        rd_chk(FSP_ADDR_CTRL, 16'h861B);
        chk({14'h0000, rx_irq, rts}, 16'h0002);
      end
      u_far.send_byte(8'h40 + 8'(i), 1 + i % 2);
      repeat (20) @(posedge clk);
    end
    rd_chk(FSP_ADDR_CTRL, 16'h861F);
    wr_reg(FSP_ADDR_CTRL, 16'h860C);
    rd_chk(FSP_ADDR_CTRL, 16'h861B);
    for (int i = 0; i < 8; i++) rd_chk(FSP_ADDR_DATA, 16'h0040 + 16'(i));
    rd_chk(FSP_ADDR_CTRL, 16'h8618);
  endtask

  task automatic t_flow;
    wr_reg(FSP_ADDR_CTRL, 16'h8800);
    u_far.send_byte(8'h13, 1);
    repeat (20) @(posedge clk);
    rd_chk(FSP_ADDR_CTRL, 16'h9810);
    n = u_far.got_cnt;
    send_tx(8'h77);
    repeat (1500) @(posedge clk);
    chk(16'(u_far.got_cnt - n), 16'h0000);
    u_far.send_byte(8'h11, 1);
    wait_rx(n + 1);
    chk({8'h00, u_far.got_byte}, 16'h0077);
    rd_chk(FSP_ADDR_CTRL, 16'h8810);
    cts <= 1'b1;
    wr_reg(FSP_ADDR_CTRL, 16'hA400);
    send_tx(8'h66);
    repeat (1500) @(posedge clk);
    chk(16'(u_far.got_cnt - n), 16'h0001);
    wr_reg(FSP_ADDR_CTRL, 16'h8400);
    wait_rx(n + 2);
    chk({8'h00, u_far.got_byte}, 16'h0066);
  endtask

  task automatic t_done;
    wr_reg(FSP_ADDR_CTRL, 16'h8100);
    blk_tx_done <= 1'b1;
    @(posedge clk);
    blk_tx_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0000, done_irq}, 16'h0001);
    rd_chk(FSP_ADDR_CTRL, 16'h8190);
    wr_reg(FSP_ADDR_CTRL, 16'h8180);
    rd_chk(FSP_ADDR_CTRL, 16'h8110);
    blk_rx_done <= 1'b1;
    @(posedge clk);
    blk_rx_done <= 1'b0;
    wr_reg(FSP_ADDR_CTRL, 16'h8000);
    repeat (3) @(posedge clk);
    chk({15'h0000, done_irq}, 16'h0000);
    rd_chk(FSP_ADDR_CTRL, 16'h8050);
    wr_reg(FSP_ADDR_CTRL, 16'h8040);
    rd_chk(FSP_ADDR_CTRL, 16'h8010);
  endtask

  task automatic t_off;
    wr_reg(FSP_ADDR_CTRL, 16'h0000);
    n = u_far.got_cnt;
    wr_reg(FSP_ADDR_DATA, 16'h0055);
    repeat (1500) @(posedge clk);
    chk(16'(u_far.got_cnt - n), 16'h0000);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_frames();
    t_rx();
    t_flow();
    t_done();
    t_off();
    give_verdict();
  end

  // watchdog
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
